//--- inc/bpu_pkg.sv
// constants for the bridge preemption, upstream window and system-error config block
package bpu_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] UP_CTRL_OFS = 8'h48;
  localparam logic [7:0] PREEMPT_OFS = 8'h4C;
  localparam logic [7:0] BASE_LIMIT_LOW_OFS = 8'h50;
  localparam logic [7:0] BASE_HIGH_OFS = 8'h54;
  localparam logic [7:0] LIMIT_HIGH_OFS = 8'h58;
  localparam logic [7:0] EVENT_MASK_OFS = 8'h64;
  localparam logic [7:0] CMD_CTRL_OFS = 8'h70;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h74;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h78;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int PREEMPT_LSB = 28;
  localparam int WIN_EN_BIT = 16;
  localparam int BASE_LSB = 4;
  localparam int LIMIT_LSB = 20;
  localparam int CAP_BASE_LSB = 0;
  localparam int CAP_LIMIT_LSB = 16;
  localparam logic [3:0] ADDR64_CAP = 4'h1;
  localparam logic [3:0] PREEMPT_RST = 4'h0;
  localparam logic [11:0] BASE_LOW_RST = 12'h000;
  localparam logic [11:0] LIMIT_LOW_RST = 12'h000;
  localparam logic [31:0] HIGH_RST = 32'h0000_0000;
  localparam logic [7:0] EVENT_MASK_RST = 8'h00;
  localparam logic [7:0] EVENT_MASK_WR = 8'h7E;
  localparam logic [19:0] LIMIT_FILL = 20'hFFFFF;
  localparam int IRQ_BITS = 2;
  localparam int IRQ_PREEMPT_BIT = 0;
  localparam int IRQ_SERR_BIT = 1;
  localparam int DELAY_W = 7;

  typedef enum logic [1:0] {PRE_IDLE, PRE_COUNT, PRE_ENABLED, PRE_HOLD} bpu_pre_state_t;

endpackage : bpu_pkg

//--- core/bpu_cfg_regs.sv
// preemption timer, upstream window decode and system-error gating with wishbone registers
`timescale 1ns/1ps
module bpu_cfg_regs
(
  input wire logic clk_sys, // 10 MHz system clock
  input wire logic arst_n, // async reset, active low
  input wire logic wbCycI, // wishbone cyc
  input wire logic wbStbI, // wishbone stb
  input wire logic wbWeI, // wishbone write enable
  input wire logic [7:0] wbAdrI, // wishbone byte address
  input wire logic [3:0] wbSelI, // wishbone byte selects
  input wire logic [31:0] wbDatI, // wishbone write data
  output logic [31:0] wbDatO, // wishbone read data
  output logic wbAckO, // wishbone acknowledge
  input wire logic secFrameAsserted, // secondary FRAME asserted, level
  output logic preemptEnable, // arbiter may preempt owner
  input wire logic [63:0] upAddr, // secondary memory address to decode
  input wire logic downWindowHit, // address falls in downstream window
  output logic upInWindow, // address inside base..limit
  output logic upIsUpstream, // address claimed for upstream
  input wire logic [6:1] errPending, // pending status per error event
  output logic primary_system_error_out_n, // system error level, active low
  output logic serrPinOut, // open-drain pin value
  output logic serrPinOeN, // open-drain enable, low drives
  output logic irq // level interrupt
);

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[8*i +: 8] = din[8*i +: 8];
      end
    end
    return res;
  endfunction

  // preemption delay for a code with top bit clear
  function automatic logic [6:0] delayOf(input logic [2:0] code);
    logic [6:0] d;
    d = 7'h00;
    if (code != 3'h0)
    begin
      d = 7'h01 << (code - 3'h1);
    end
    return d;
  endfunction

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic winEnable, next_winEnable;
  logic [3:0] preemptCode, next_preemptCode;
  logic [11:0] baseLow, next_baseLow;
  logic [11:0] limitLow, next_limitLow;
  logic [31:0] baseHigh, next_baseHigh;
  logic [31:0] limitHigh, next_limitHigh;
  logic [7:0] eventMask, next_eventMask;
  logic cmd_system_error_enable, next_cmd_system_error_enable;
  logic [1:0] irqStatus, next_irqStatus;
  logic [1:0] irqMask, next_irqMask;
  logic [31:0] next_wbDatO;
  logic next_wbAckO;
  logic access, doWrite, doRead;
  logic [31:0] rdWord, wrWord;
  logic [1:0] irqEvent;

  assign access = wbCycI & wbStbI & ~wbAckO;
  assign doWrite = access & wbWeI;
  assign doRead = access & ~wbWeI;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb
  begin
    rdWord = 32'h0000_0000;
    case (wbAdrI)
      bpu_pkg::UP_CTRL_OFS: rdWord[bpu_pkg::WIN_EN_BIT] = winEnable;
      bpu_pkg::PREEMPT_OFS: rdWord[bpu_pkg::PREEMPT_LSB +: 4] = preemptCode;
      bpu_pkg::BASE_LIMIT_LOW_OFS:
      begin
        rdWord[bpu_pkg::CAP_BASE_LSB +: 4] = bpu_pkg::ADDR64_CAP;
        rdWord[bpu_pkg::CAP_LIMIT_LSB +: 4] = bpu_pkg::ADDR64_CAP;
        rdWord[bpu_pkg::BASE_LSB +: 12] = baseLow;
        rdWord[bpu_pkg::LIMIT_LSB +: 12] = limitLow;
      end
      bpu_pkg::BASE_HIGH_OFS: rdWord = baseHigh;
      bpu_pkg::LIMIT_HIGH_OFS: rdWord = limitHigh;
      bpu_pkg::EVENT_MASK_OFS: rdWord[7:0] = eventMask;
      bpu_pkg::CMD_CTRL_OFS: rdWord[0] = cmd_system_error_enable;
      bpu_pkg::IRQ_STATUS_OFS: rdWord[1:0] = irqStatus;
      bpu_pkg::IRQ_MASK_OFS: rdWord[1:0] = irqMask;
      default: rdWord = 32'h0000_0000;
    endcase
  end

  assign wrWord = merge(rdWord, wbDatI, wbSelI);

  // ---------------------------------------------------------------
  // register writes and bus answer
  // ---------------------------------------------------------------
  always_comb
  begin
    next_winEnable = winEnable;
    next_preemptCode = preemptCode;
    next_baseLow = baseLow;
    next_limitLow = limitLow;
    next_baseHigh = baseHigh;
    next_limitHigh = limitHigh;
    next_eventMask = eventMask;
    next_cmd_system_error_enable = cmd_system_error_enable;
    next_irqMask = irqMask;
    next_wbAckO = access;
    next_wbDatO = wbDatO;
    if (doRead)
    begin
      next_wbDatO = rdWord;
    end
    if (doWrite)
    begin
      case (wbAdrI)
        bpu_pkg::UP_CTRL_OFS: next_winEnable = wrWord[bpu_pkg::WIN_EN_BIT];
        bpu_pkg::PREEMPT_OFS: next_preemptCode = wrWord[bpu_pkg::PREEMPT_LSB +: 4];
        bpu_pkg::BASE_LIMIT_LOW_OFS:
        begin
          next_baseLow = wrWord[bpu_pkg::BASE_LSB +: 12];
          next_limitLow = wrWord[bpu_pkg::LIMIT_LSB +: 12];
        end
        bpu_pkg::BASE_HIGH_OFS: next_baseHigh = wrWord;
        bpu_pkg::LIMIT_HIGH_OFS: next_limitHigh = wrWord;
        // bits 0 and 7 stay zero
        bpu_pkg::EVENT_MASK_OFS: next_eventMask = wrWord[7:0] & bpu_pkg::EVENT_MASK_WR;
        bpu_pkg::CMD_CTRL_OFS: next_cmd_system_error_enable = wrWord[0];
        bpu_pkg::IRQ_MASK_OFS: next_irqMask = wrWord[1:0];
        default: next_winEnable = winEnable;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      winEnable <= 1'b0;
      preemptCode <= bpu_pkg::PREEMPT_RST;
      baseLow <= bpu_pkg::BASE_LOW_RST;
      limitLow <= bpu_pkg::LIMIT_LOW_RST;
      baseHigh <= bpu_pkg::HIGH_RST;
      limitHigh <= bpu_pkg::HIGH_RST;
      eventMask <= bpu_pkg::EVENT_MASK_RST;
      cmd_system_error_enable <= 1'b0;
      irqMask <= 2'h0;
      wbAckO <= 1'b0;
      wbDatO <= 32'h0000_0000;
    end
    else
    begin
      winEnable <= next_winEnable;
      preemptCode <= next_preemptCode;
      baseLow <= next_baseLow;
      limitLow <= next_limitLow;
      baseHigh <= next_baseHigh;
      limitHigh <= next_limitHigh;
      eventMask <= next_eventMask;
      cmd_system_error_enable <= next_cmd_system_error_enable;
      irqMask <= next_irqMask;
      wbAckO <= next_wbAckO;
      wbDatO <= next_wbDatO;
    end
  end

  // ---------------------------------------------------------------
  // preemption timer
  // ---------------------------------------------------------------
  bpu_pkg::bpu_pre_state_t preState, next_preState;
  logic [6:0] preCount, next_preCount;
  logic next_preemptEnable;
  logic [6:0] preDelay;

  assign preDelay = delayOf(preemptCode[2:0]);

  always_comb
  begin
    next_preState = preState;
    next_preCount = preCount;
    case (preState)
      bpu_pkg::PRE_IDLE:
      begin
        next_preCount = 7'h00;
        if (secFrameAsserted)
        begin
          if (preemptCode[3])
          begin
            next_preState = bpu_pkg::PRE_HOLD;
          end
          else if (preDelay == 7'h00)
          begin
            next_preState = bpu_pkg::PRE_ENABLED;
          end
          else
          begin
            next_preState = bpu_pkg::PRE_COUNT;
          end
        end
      end
      bpu_pkg::PRE_COUNT:
      begin
        next_preCount = preCount + 7'h01;
        if (!secFrameAsserted)
        begin
          next_preState = bpu_pkg::PRE_IDLE;
        end
        else if (preemptCode[3])
        begin
          next_preState = bpu_pkg::PRE_HOLD;
        end
        else if (next_preCount >= preDelay)
        begin
          next_preState = bpu_pkg::PRE_ENABLED;
        end
      end
      bpu_pkg::PRE_ENABLED, bpu_pkg::PRE_HOLD:
      begin
        if (!secFrameAsserted)
        begin
          next_preState = bpu_pkg::PRE_IDLE;
        end
      end
      default:
      begin
        next_preState = bpu_pkg::PRE_IDLE;
      end
    endcase
    next_preemptEnable = (next_preState == bpu_pkg::PRE_ENABLED) & ~preemptCode[3];
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      preState <= bpu_pkg::PRE_IDLE;
      preCount <= 7'h00;
      preemptEnable <= 1'b0;
    end
    else
    begin
      preState <= next_preState;
      preCount <= next_preCount;
      preemptEnable <= next_preemptEnable;
    end
  end

  // ---------------------------------------------------------------
  // upstream window decode
  // ---------------------------------------------------------------
  logic [63:0] winBase, winLimit;
  logic next_upInWindow, next_upIsUpstream;

  always_comb
  begin
    winBase = {baseHigh, baseLow, 20'h00000};
    winLimit = {limitHigh, limitLow, bpu_pkg::LIMIT_FILL};
    next_upInWindow = (upAddr >= winBase) && (upAddr <= winLimit);
    next_upIsUpstream = winEnable ? next_upInWindow : ~downWindowHit;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      upInWindow <= 1'b0;
      upIsUpstream <= 1'b0;
    end
    else
    begin
      upInWindow <= next_upInWindow;
      upIsUpstream <= next_upIsUpstream;
    end
  end

  // ---------------------------------------------------------------
  // system error gating
  // ---------------------------------------------------------------
  logic next_serrOutN;
  logic [6:1] liveEvents;

  always_comb
  begin
    liveEvents = errPending & ~eventMask[6:1];
    // enable and an unmasked pending event drive low
    next_serrOutN = ~(cmd_system_error_enable & (|liveEvents));
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      primary_system_error_out_n <= 1'b1;
    end
    else
    begin
      primary_system_error_out_n <= next_serrOutN;
    end
  end

  assign serrPinOut = 1'b0;
  assign serrPinOeN = primary_system_error_out_n;

  // ---------------------------------------------------------------
  // interrupt status, cleared by read, set wins
  // ---------------------------------------------------------------
  always_comb
  begin
    irqEvent = 2'h0;
    irqEvent[bpu_pkg::IRQ_PREEMPT_BIT] = next_preemptEnable & ~preemptEnable;
    irqEvent[bpu_pkg::IRQ_SERR_BIT] = ~next_serrOutN & primary_system_error_out_n;
    next_irqStatus = irqStatus;
    if (doRead && (wbAdrI == bpu_pkg::IRQ_STATUS_OFS))
    begin
      next_irqStatus = 2'h0;
    end
    next_irqStatus = next_irqStatus | irqEvent;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irqStatus <= 2'h0;
      irq <= 1'b0;
    end
    else
    begin
      irqStatus <= next_irqStatus;
      irq <= |(next_irqStatus & irqMask);
    end
  end

endmodule // bpu_cfg_regs

//--- sim/bpu_cfg_regs_props.sv
// port-level checker of the config register block
`timescale 1ns/1ps
module bpu_cfg_props
(
  input wire logic clk_sys, // clock
  input wire logic arst_n, // reset, active low
  input wire logic wbCycI, // cyc
  input wire logic wbStbI, // stb
  input wire logic wbWeI, // write enable
  input wire logic [7:0] wbAdrI, // address
  input wire logic [3:0] wbSelI, // byte selects
  input wire logic [31:0] wbDatI, // write data
  input wire logic [31:0] wbDatO, // read data
  input wire logic wbAckO, // ack
  input wire logic secFrameAsserted, // frame seen
  input wire logic preemptEnable, // preempt allowed
  input wire logic [63:0] upAddr, // decoded address
  input wire logic downWindowHit, // downstream hit
  input wire logic upInWindow, // window hit
  input wire logic upIsUpstream, // upstream claim
  input wire logic [6:1] errPending, // event status
  input wire logic primary_system_error_out_n, // system error
  input wire logic serrPinOut, // pin value
  input wire logic serrPinOeN, // pin enable
  input wire logic irq // interrupt
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  property p_ackNext; wbCycI && wbStbI && !wbAckO |=> wbAckO; endproperty
  a_ackNext: assert property (p_ackNext) else $error("ack late");
  property p_ackOne; wbAckO |=> !wbAckO; endproperty
  a_ackOne: assert property (p_ackOne) else $error("ack too long");
  property p_serrCause; !primary_system_error_out_n |-> $past(errPending) != 6'h00; endproperty
  a_serrCause: assert property (p_serrCause) else $error("error without event");
  property p_serrClear; errPending == 6'h00 |=> primary_system_error_out_n; endproperty
  a_serrClear: assert property (p_serrClear) else $error("error held too long");
  property p_pinFollow; serrPinOeN == primary_system_error_out_n && !serrPinOut; endproperty
  a_pinFollow: assert property (p_pinFollow) else $error("pin drive wrong");
  property p_preemptFrame; preemptEnable |-> $past(secFrameAsserted); endproperty
  a_preemptFrame: assert property (p_preemptFrame) else $error("preempt w/o frame");
  property p_claimed; upInWindow && !$past(downWindowHit) |-> upIsUpstream; endproperty
  a_claimed: assert property (p_claimed) else $error("window hit not claimed");
  property p_notClaimed; $past(downWindowHit) && !upInWindow |-> !upIsUpstream; endproperty
  a_notClaimed: assert property (p_notClaimed) else $error("downstream claimed");

  c_preempt: cover property (preemptEnable);
  c_serr: cover property (!primary_system_error_out_n);
  c_irq: cover property (irq);
endmodule // bpu_cfg_props

bind bpu_cfg_regs bpu_cfg_props bpu_cfg_props_i (.clk_sys(clk_sys), .arst_n(arst_n),
  .wbCycI(wbCycI), .wbStbI(wbStbI), .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI),
  .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAckO(wbAckO), .secFrameAsserted(secFrameAsserted),
  .preemptEnable(preemptEnable), .upAddr(upAddr), .downWindowHit(downWindowHit),
  .upInWindow(upInWindow), .upIsUpstream(upIsUpstream), .errPending(errPending),
  .primary_system_error_out_n(primary_system_error_out_n), .serrPinOut(serrPinOut),
  .serrPinOeN(serrPinOeN), .irq(irq));

//--- sim/bpu_cfg_host.sv
// configuration master model issuing classic wishbone cycles
`timescale 1ns/1ps
module bpu_cfg_host
(
  input wire logic clk_sys, // clock
  output logic wbCycI, // cyc
  output logic wbStbI, // stb
  output logic wbWeI, // write enable
  output logic [7:0] wbAdrI, // address
  output logic [3:0] wbSelI, // byte selects
  output logic [31:0] wbDatI, // write data
  input wire logic [31:0] wbDatO, // read data
  input wire logic wbAckO // ack
);
  initial
  begin
    wbCycI = 1'b0;
    wbStbI = 1'b0;
    wbWeI = 1'b0;
    wbAdrI = 8'hA5;
    wbSelI = 4'h0;
    wbDatI = 32'h5A5A_5A5A;
  end

  // one cycle, held until ack; released address and data show inverted values, cyc/stb/we/sel go low
  task automatic wbAccess(input logic we, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    @(posedge clk_sys);
    wbCycI <= 1'b1;
    wbStbI <= 1'b1;
    wbWeI <= we;
    wbAdrI <= a;
    wbSelI <= 4'hF;
    wbDatI <= d;
    do @(posedge clk_sys); while (wbAckO !== 1'b1);
    q = wbDatO;
    wbCycI <= 1'b0;
    wbStbI <= 1'b0;
    wbWeI <= 1'b0;
    wbAdrI <= ~a;
    wbSelI <= 4'h0;
    wbDatI <= ~d;
  endtask

  task automatic wbWrite(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wbAccess(1'b1, a, d, q);
  endtask

  task automatic wbRead(input logic [7:0] a, output logic [31:0] q);
    wbAccess(1'b0, a, 32'h0000_0000, q);
  endtask
endmodule // bpu_cfg_host

//--- sim/bpu_cfg_regs_test.sv
// self-checking bench of the config register block
`timescale 1ns/1ps
`define CHK(g, e) \
  begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module bpu_cfg_regs_test;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic wbCycI, wbStbI, wbWeI, wbAckO, secFrameAsserted, preemptEnable, downWindowHit;
  logic upInWindow, upIsUpstream, primary_system_error_out_n, serrPinOut, serrPinOeN, irq;
  logic [7:0] wbAdrI;
  logic [3:0] wbSelI;
  logic [31:0] wbDatI, wbDatO, rd;
  logic [63:0] upAddr;
  logic [6:1] errPending, ev;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  int delays[8] = '{0, 1, 2, 4, 8, 16, 32, 64};
  logic [63:0] addrs[4] = '{64'h1_1230_0000, 64'h1_122F_FFFF, 64'h1_456F_FFFF, 64'h1_4570_0000};
  logic [3:0] inWin = 4'b1010;

  always #50 clk_sys = ~clk_sys;

  bpu_cfg_host bpu_cfg_host_i (.clk_sys(clk_sys), .wbCycI(wbCycI), .wbStbI(wbStbI),
    .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI), .wbDatI(wbDatI), .wbDatO(wbDatO),
    .wbAckO(wbAckO));
  bpu_cfg_regs bpu_cfg_regs_i (.clk_sys(clk_sys), .arst_n(arst_n), .wbCycI(wbCycI),
    .wbStbI(wbStbI), .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI), .wbDatI(wbDatI),
    .wbDatO(wbDatO), .wbAckO(wbAckO), .secFrameAsserted(secFrameAsserted),
    .preemptEnable(preemptEnable), .upAddr(upAddr), .downWindowHit(downWindowHit),
    .upInWindow(upInWindow), .upIsUpstream(upIsUpstream), .errPending(errPending),
    .primary_system_error_out_n(primary_system_error_out_n), .serrPinOut(serrPinOut),
    .serrPinOeN(serrPinOeN), .irq(irq));

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bpu_cfg_host_i.wbWrite(a, d);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    bpu_cfg_host_i.wbRead(a, rd);
    `CHK(rd, e)
  endtask

  task automatic frameRun(input int lim);
    n = 0;
    secFrameAsserted <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (preemptEnable !== 1'b1 && n < lim);
  endtask

  task print_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  initial
  begin
    secFrameAsserted = 1'b0;
    upAddr = 64'h0;
    downWindowHit = 1'b0;
    errPending = 6'h00;
    tick(4);
    arst_n <= 1'b1;
    rdChk(8'h4C, 32'h0);
    rdChk(8'h50, 32'h0001_0001);
    rdChk(8'h54, 32'h0);
    rdChk(8'h58, 32'h0);
    rdChk(8'h64, 32'h0);
    wr(8'h50, 32'hFFFF_FFFF);
    rdChk(8'h50, 32'hFFF1_FFF1);
    wr(8'h54, 32'hA5C3_0001);
    rdChk(8'h54, 32'hA5C3_0001);
    wr(8'h58, 32'h3C5A_0001);
    rdChk(8'h58, 32'h3C5A_0001);
    wr(8'h64, 32'hFFFF_FFFF);
    rdChk(8'h64, 32'h0000_007E);
    wr(8'h80, 32'hFFFF_FFFF);
    rdChk(8'h80, 32'h0);
    wr(8'h4C, 32'hFFFF_FFFF);
    rdChk(8'h4C, 32'hF000_0000);
    // ---------------------------------------------------------------
    // preemption delay per code
    // ---------------------------------------------------------------
    for (int c = 0; c < 9; c++)
    begin
      wr(8'h4C, {c[3:0], 28'h0});
      frameRun(100);
      `CHK(n, (c < 8) ? delays[c] + 2 : 100)
      secFrameAsserted <= 1'b0;
      tick(3);
      `CHK(preemptEnable, 1'b0)
    end
    // ---------------------------------------------------------------
    // system error gating per event
    // ---------------------------------------------------------------
    wr(8'h70, 32'h1);
    for (int i = 1; i < 7; i++)
    begin
      ev = 6'h00;
      ev[i] = 1'b1;
      wr(8'h64, 32'h1 << i);
      errPending <= ev;
      tick(2);
      `CHK(primary_system_error_out_n, 1'b1)
      wr(8'h64, 32'h0);
      tick(2);
      `CHK(primary_system_error_out_n, 1'b0)
      errPending <= 6'h00;
      tick(2);
      `CHK(primary_system_error_out_n, 1'b1)
    end
    errPending <= 6'h3F;
    wr(8'h70, 32'h0);
    tick(2);
    `CHK(serrPinOeN, 1'b1)
    wr(8'h70, 32'h1);
    tick(2);
    `CHK(serrPinOeN, 1'b0)
    errPending <= 6'h00;
    // ---------------------------------------------------------------
    // interrupt raise, clear and mask
    // ---------------------------------------------------------------
    wr(8'h78, 32'h3);
    bpu_cfg_host_i.wbRead(8'h74, rd);
    tick(2);
    `CHK(irq, 1'b0)
    wr(8'h4C, 32'h0);
    frameRun(10);
    secFrameAsserted <= 1'b0;
    tick(3);
    `CHK(irq, 1'b1)
    rdChk(8'h74, 32'h1);
    tick(2);
    `CHK(irq, 1'b0)
    wr(8'h78, 32'h0);
    errPending <= 6'h01;
    tick(3);
    `CHK(irq, 1'b0)
    rdChk(8'h74, 32'h2);
    errPending <= 6'h00;
    // ---------------------------------------------------------------
    // upstream window decode
    // ---------------------------------------------------------------
    wr(8'h50, 32'h4560_1230);
    wr(8'h54, 32'h1);
    wr(8'h58, 32'h1);
    wr(8'h48, 32'hFFFF_FFFF);
    rdChk(8'h48, 32'h0001_0000);
    for (int k = 0; k < 4; k++)
    begin
      upAddr <= addrs[k];
      tick(2);
      `CHK(upInWindow, inWin[3 - k])
      `CHK(upIsUpstream, inWin[3 - k])
    end
    wr(8'h48, 32'h0);
    tick(2);
    `CHK(upIsUpstream, 1'b1)
    downWindowHit <= 1'b1;
    tick(2);
    `CHK(upIsUpstream, 1'b0)
    print_verdict();
  end
endmodule // bpu_cfg_regs_test
